// ---- common/thpa_pkg.sv ----
package thpa_pkg;
    // register offsets on the host register port
    localparam logic [11:0] SELECT_OFFSET   = 12'h380;
    localparam logic [11:0] DATA_ONE_OFFSET = 12'h384;

    // select register field positions
    localparam int          SEL_BUSY_BIT    = 15;
    localparam int          SEL_DIR_BIT     = 14;
    localparam int          SEL_RSVD_LSB    = 8;
    localparam int          SEL_CHANNEL_NUMBER_LSB    = 0;

    // data one register field positions
    localparam int          D1_PROVISION_ENABLE_BIT     = 15;
    localparam int          D1_CRC_LSB      = 13;
    localparam int          D1_DELINEATION_ENABLE_BIT    = 12;
    localparam int          D1_RSVD_BIT     = 11;
    localparam int          D1_FIFO_BLOCK_POINTER_LSB     = 0;

    // reset values
    localparam logic [7:0]  CHANNEL_NUMBER_RESET      = 8'h00;
    localparam logic [1:0]  SEL_RSVD_RESET  = 2'h0;
    localparam logic        DIR_RESET       = 1'b0;
    localparam logic        BUSY_RESET      = 1'b0;
    localparam logic [15:0] DATA_ONE_RESET  = 16'h0000;

    // access direction encoding
    localparam logic        DIR_WRITE       = 1'b0;
    localparam logic        DIR_READ        = 1'b1;

    // all byte enables negated (active low lanes)
    localparam logic [3:0]  BE_NONE         = 4'hf;

    // check sequence selector
    typedef enum logic [1:0] {
        THPA_CRC_NONE  = 2'b00,
        THPA_CRC_CCITT = 2'b01,
        THPA_CRC_32    = 2'b10,
        THPA_CRC_RSVD  = 2'b11
    } thpa_crc_t;

    // one channel's provisioning word
    typedef struct packed {
        logic        provision_enable;
        thpa_crc_t   crc_select;
        logic        delineation_enable;
        logic        reserved;
        logic [10:0] fifo_block_pointer;
    } thpa_entry_t;

    // configuration handed to the transmit frame processor
    typedef struct packed {
        logic        serve;
        logic        insert_flags;
        logic        bit_stuff;
        thpa_crc_t   crc_mode;
        logic [10:0] fifo_block_pointer;
    } thpa_channel_number_cfg_t;
endpackage

// ---- verilog/thpa_provision_enable_mem.sv ----
module thpa_provision_enable_mem #(
    parameter int DEPTH = 256,
    parameter int WIDTH = 16,
    parameter int AW    = 8
) (
    input  wire logic             clk,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    host_addr,
    output logic      [WIDTH-1:0] host_rdata,
    input  wire logic [AW-1:0]    proc_addr,
    output logic      [WIDTH-1:0] proc_rdata
);
    logic [WIDTH-1:0] store [DEPTH];

    ////////////////////////////////////////////////////////////////////////
    // one write port, two registered read ports
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            store[wr_addr] <= wr_data;
        end
        host_rdata <= store[host_addr];
        proc_rdata <= store[proc_addr];
    end
endmodule

// ---- verilog/thpa_access.sv ----
// Overview of operation
// - any select write starts one indirect access for channel bits 7:0
// - direction zero writes the data register contents into memory
// - direction one reads memory into the data register
// - busy rises on select write, stays through access, then falls
// - writes update all bits; all byte enables negated means no access
// - write-only fifo block pointer in bits 10:0 picks the channel fifo
// - delineation enable gives flags, stuffing, crc; else raw passthrough
// - crc selector 00 none, 01 ccitt, 10 crc-32; ignored without delineation
// - provision enable decides whether assigner data requests are served
// - readable fields hold last host write until an indirect read completes
module thpa_access #(
    parameter int CHANNELS = 256,
    parameter int CHANNEL_NUMBER_W   = 8
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    input  wire logic [11:0]              reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic [3:0]               bus_byte_enables_n,
    output logic      [31:0]              reg_rdata,
    output logic                          reg_rdata_valid,
    input  wire logic                     req_valid,
    input  wire logic [CHANNEL_NUMBER_W-1:0]        req_channel,
    output logic                          cfg_valid,
    output logic      [CHANNEL_NUMBER_W-1:0]        cfg_channel,
    output thpa_pkg::thpa_channel_number_cfg_t      cfg
);
    typedef enum logic [1:0] {
        THPA_IDLE,
        THPA_ISSUE,
        THPA_FETCH
    } thpa_state_t;

    ////////////////////////////////////////////////////////////////////////
    // state
    thpa_state_t              state;
    thpa_state_t              next_state;
    logic                     busy;
    logic                     next_busy;
    logic                     dir;
    logic                     next_dir;
    logic [7:0]               channel_number;
    logic [7:0]               next_channel_number;
    logic [1:0]               sel_rsvd;
    logic [1:0]               next_sel_rsvd;
    thpa_pkg::thpa_entry_t    data_one;
    thpa_pkg::thpa_entry_t    next_data_one;
    logic [31:0]              next_reg_rdata;
    logic                     next_reg_rdata_valid;

    logic                     bus_active;
    logic                     sel_hit;
    logic                     d1_hit;
    logic                     mem_wr;
    logic [15:0]              host_rdata;
    logic [15:0]              proc_rdata;
    thpa_pkg::thpa_entry_t    proc_entry;

    logic                     pipe_valid;
    logic                     next_pipe_valid;
    logic [CHANNEL_NUMBER_W-1:0]        pipe_channel_number;
    logic [CHANNEL_NUMBER_W-1:0]        next_pipe_channel_number;
    logic                     next_cfg_valid;
    logic [CHANNEL_NUMBER_W-1:0]        next_cfg_channel;
    thpa_pkg::thpa_channel_number_cfg_t next_cfg;

    ////////////////////////////////////////////////////////////////////////
    // address decode; no lanes enabled means the register is untouched
    assign bus_active = bus_byte_enables_n != thpa_pkg::BE_NONE;
    assign sel_hit    = bus_active && reg_addr == thpa_pkg::SELECT_OFFSET;
    assign d1_hit     = bus_active && reg_addr == thpa_pkg::DATA_ONE_OFFSET;
    assign mem_wr     = state == THPA_ISSUE && dir == thpa_pkg::DIR_WRITE;

    ////////////////////////////////////////////////////////////////////////
    // provisioning memory
    thpa_provision_enable_mem #(
        .DEPTH      (CHANNELS),
        .WIDTH      (16),
        .AW         (CHANNEL_NUMBER_W)
    ) u_mem (
        .clk        (clk),
        .wr_en      (mem_wr),
        .wr_addr    (channel_number[CHANNEL_NUMBER_W-1:0]),
        .wr_data    (data_one),
        .host_addr  (channel_number[CHANNEL_NUMBER_W-1:0]),
        .host_rdata (host_rdata),
        .proc_addr  (req_channel),
        .proc_rdata (proc_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // indirect access sequencer and host registers
    always_comb
    begin
        next_state    = state;
        next_busy     = busy;
        next_dir      = dir;
        next_channel_number     = channel_number;
        next_sel_rsvd = sel_rsvd;
        next_data_one = data_one;
        case (state)
            THPA_IDLE:
            begin
                next_state = THPA_IDLE;
            end
            THPA_ISSUE:
            begin
                if (dir == thpa_pkg::DIR_READ)
                begin
                    next_state = THPA_FETCH;
                end
                else
                begin
                    next_state = THPA_IDLE;
                    next_busy  = 1'b0;
                end
            end
            THPA_FETCH:
            begin
                next_data_one = host_rdata;
                next_data_one.reserved = 1'b0;
                next_state    = THPA_IDLE;
                next_busy     = 1'b0;
            end
            default:
            begin
                next_state = THPA_IDLE;
                next_busy  = 1'b0;
            end
        endcase
        // a completing read wins over a host data write in the same cycle
        if (reg_wr && d1_hit && state != THPA_FETCH)
        begin
            next_data_one = reg_wdata[15:0];
        end
        // any select write restarts the access
        if (reg_wr && sel_hit)
        begin
            next_channel_number     = reg_wdata[thpa_pkg::SEL_CHANNEL_NUMBER_LSB +: 8];
            next_dir      = reg_wdata[thpa_pkg::SEL_DIR_BIT];
            next_sel_rsvd = reg_wdata[thpa_pkg::SEL_RSVD_LSB +: 2];
            next_state    = THPA_ISSUE;
            next_busy     = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state    <= THPA_IDLE;
            busy     <= thpa_pkg::BUSY_RESET;
            dir      <= thpa_pkg::DIR_RESET;
            channel_number     <= thpa_pkg::CHANNEL_NUMBER_RESET;
            sel_rsvd <= thpa_pkg::SEL_RSVD_RESET;
            data_one <= thpa_pkg::DATA_ONE_RESET;
        end
        else
        begin
            state    <= next_state;
            busy     <= next_busy;
            dir      <= next_dir;
            channel_number     <= next_channel_number;
            sel_rsvd <= next_sel_rsvd;
            data_one <= next_data_one;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read path; write-only bits and unused bits read zero
    always_comb
    begin
        next_reg_rdata       = 32'h0000_0000;
        next_reg_rdata_valid = 1'b0;
        if (reg_rd && bus_active)
        begin
            next_reg_rdata_valid = 1'b1;
            if (reg_addr == thpa_pkg::SELECT_OFFSET)
            begin
                next_reg_rdata[thpa_pkg::SEL_BUSY_BIT]      = busy;
                next_reg_rdata[thpa_pkg::SEL_DIR_BIT]       = dir;
                next_reg_rdata[thpa_pkg::SEL_RSVD_LSB +: 2] = sel_rsvd;
                next_reg_rdata[thpa_pkg::SEL_CHANNEL_NUMBER_LSB +: 8] = channel_number;
            end
            else if (reg_addr == thpa_pkg::DATA_ONE_OFFSET)
            begin
                next_reg_rdata[thpa_pkg::D1_PROVISION_ENABLE_BIT] =
                    data_one.provision_enable;
                next_reg_rdata[thpa_pkg::D1_CRC_LSB +: 2] =
                    data_one.crc_select;
                next_reg_rdata[thpa_pkg::D1_DELINEATION_ENABLE_BIT] =
                    data_one.delineation_enable;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            reg_rdata       <= 32'h0000_0000;
            reg_rdata_valid <= 1'b0;
        end
        else
        begin
            reg_rdata       <= next_reg_rdata;
            reg_rdata_valid <= next_reg_rdata_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-channel configuration lookup for the transmit frame processor
    assign proc_entry = proc_rdata;

    always_comb
    begin
        next_pipe_valid  = req_valid;
        next_pipe_channel_number   = req_channel;
        next_cfg_valid   = pipe_valid;
        next_cfg_channel = pipe_channel_number;
        next_cfg         = '0;
        next_cfg.serve   = pipe_valid && proc_entry.provision_enable;
        next_cfg.fifo_block_pointer = proc_entry.fifo_block_pointer;
        if (proc_entry.delineation_enable)
        begin
            next_cfg.insert_flags = 1'b1;
            next_cfg.bit_stuff    = 1'b1;
            if (proc_entry.crc_select != thpa_pkg::THPA_CRC_RSVD)
            begin
                next_cfg.crc_mode = proc_entry.crc_select;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pipe_valid  <= 1'b0;
            pipe_channel_number   <= '0;
            cfg_valid   <= 1'b0;
            cfg_channel <= '0;
            cfg         <= '0;
        end
        else
        begin
            pipe_valid  <= next_pipe_valid;
            pipe_channel_number   <= next_pipe_channel_number;
            cfg_valid   <= next_cfg_valid;
            cfg_channel <= next_cfg_channel;
            cfg         <= next_cfg;
        end
    end
endmodule

// ---- verification/thpa_access_props.sv ----
////////////////////////////////////////////////////////////////////////
module thpa_access_props #(
    parameter int CHANNELS = 256,
    parameter int CHANNEL_NUMBER_W   = 8
) (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [11:0]           reg_addr,
    input wire logic [31:0]           reg_wdata,
    input wire logic [3:0]            bus_byte_enables_n,
    input wire logic [31:0]           reg_rdata,
    input wire logic                  reg_rdata_valid,
    input wire logic                  req_valid,
    input wire logic [CHANNEL_NUMBER_W-1:0]     req_channel,
    input wire logic                  cfg_valid,
    input wire logic [CHANNEL_NUMBER_W-1:0]     cfg_channel,
    input wire thpa_pkg::thpa_channel_number_cfg_t cfg
);
    timeunit 1ns;
    timeprecision 1ns;

    // decoded host strobes
    logic lanes;
    logic wr_sel;
    logic rd_sel;
    assign lanes  = bus_byte_enables_n != thpa_pkg::BE_NONE;
    assign wr_sel = reg_wr && lanes && reg_addr == thpa_pkg::SELECT_OFFSET;
    assign rd_sel = reg_rd && lanes && reg_addr == thpa_pkg::SELECT_OFFSET;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // steps of an indirect read and of a lookup
    sequence s_rd_start; wr_sel && reg_wdata[14] ##2 rd_sel; endsequence
    sequence s_quiet; !wr_sel [*3] ##1 rd_sel; endsequence
    sequence s_lookup; req_valid ##2 cfg_valid; endsequence

    // register port answers
    property p_rd_ans; reg_rd && lanes |=> reg_rdata_valid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
    property p_rd_none; !(reg_rd && lanes) |=> !reg_rdata_valid; endproperty
    a_rd_none: assert property (p_rd_none) else $error("stray read");
    property p_rd_busy; s_rd_start |=> reg_rdata[15]; endproperty
    a_rd_busy: assert property (p_rd_busy) else $error("busy low");
    property p_rd_idle; s_quiet |=> !reg_rdata[15]; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("busy stuck");

    // configuration lookups
    property p_cfg_lat; req_valid |-> ##2 cfg_valid; endproperty
    a_cfg_lat: assert property (p_cfg_lat) else $error("no answer");
    property p_cfg_src; cfg_valid |-> $past(req_valid, 2); endproperty
    a_cfg_src: assert property (p_cfg_src) else $error("stray cfg");
    property p_cfg_channel_number;
        s_lookup |-> cfg_channel == $past(req_channel, 2);
    endproperty
    a_cfg_channel_number: assert property (p_cfg_channel_number) else $error("bad channel_number");
    property p_delineation_enable; cfg_valid |-> cfg.insert_flags == cfg.bit_stuff;
    endproperty
    a_delineation_enable: assert property (p_delineation_enable) else $error("flags split");
    property p_crc_off;
        cfg_valid && !cfg.insert_flags |-> cfg.crc_mode == 2'b00;
    endproperty
    a_crc_off: assert property (p_crc_off) else $error("crc on");
    property p_crc_rsvd; cfg_valid |-> cfg.crc_mode != 2'b11; endproperty
    a_crc_rsvd: assert property (p_crc_rsvd) else $error("crc code");
endmodule

////////////////////////////////////////////////////////////////////////
bind thpa_access thpa_access_props #(
    .CHANNELS(CHANNELS),
    .CHANNEL_NUMBER_W(CHANNEL_NUMBER_W)
) u_props (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .bus_byte_enables_n(bus_byte_enables_n), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .req_valid(req_valid),
    .req_channel(req_channel), .cfg_valid(cfg_valid),
    .cfg_channel(cfg_channel), .cfg(cfg)
);

// ---- verification/tx_hdlc_channel_provision_access_test.sv ----
module tx_hdlc_channel_provision_access_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic                     clk = 1'b0;
    logic                     rst = 1'b1;
    logic                     reg_wr = 1'b0;
    logic                     reg_rd = 1'b0;
    logic [11:0]              reg_addr = 12'h000;
    logic [31:0]              reg_wdata = 32'h0;
    logic [3:0]               bus_byte_enables_n = 4'hf;
    logic [31:0]              reg_rdata;
    logic                     reg_rdata_valid;
    logic                     req_valid = 1'b0;
    logic [7:0]               req_channel = 8'h00;
    logic                     cfg_valid;
    logic [7:0]               cfg_channel;
    thpa_pkg::thpa_channel_number_cfg_t cfg;
    logic [31:0]              rd_q[$];
    logic [31:0]              cfg_q[$];
    int                       failures = 0;
    int                       n_checks = 0;
    int                       seed = 32'h30fa;
    logic [7:0]               c;
    logic [15:0]              d;
    localparam logic [11:0]   SEL = thpa_pkg::SELECT_OFFSET;
    localparam logic [11:0]   D1 = thpa_pkg::DATA_ONE_OFFSET;

    thpa_access u_dut (
        .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .bus_byte_enables_n(bus_byte_enables_n), .reg_rdata(reg_rdata),
        .reg_rdata_valid(reg_rdata_valid), .req_valid(req_valid),
        .req_channel(req_channel), .cfg_valid(cfg_valid),
        .cfg_channel(cfg_channel), .cfg(cfg)
    );

    // 10 MHz clock
    always #50 clk = ~clk;

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        check(32'(rd_q.size() + cfg_q.size()), 32'h0);
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // one host cycle, driven at the falling edge
    task automatic acc(input logic w, input logic r, input logic [11:0] a,
                       input logic [31:0] v, input logic [3:0] be);
        @(negedge clk);
        reg_wr = w;
        reg_rd = r;
        reg_addr = a;
        reg_wdata = v;
        bus_byte_enables_n = be;
    endtask

    // random lane pattern with at least one lane enabled
    function automatic logic [3:0] lane();
        logic [3:0] be;
        be = 4'($random(seed));
        return (be == 4'hf) ? 4'h0 : be;
    endfunction

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        acc(1'b1, 1'b0, a, v, lane());
        acc(1'b0, 1'b0, a, 32'h0, 4'hf);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        acc(1'b0, 1'b1, a, 32'h0, lane());
        acc(1'b0, 1'b0, a, 32'h0, 4'hf);
    endtask

    function automatic logic [31:0] sel(logic b, logic r, logic [7:0] ch);
        return {16'h0, b, r, 6'h0, ch};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // result monitor: oldest note against each answer
    always @(negedge clk)
    begin
        if (reg_rdata_valid === 1'b1)
            check(reg_rdata, rd_q.size() ? rd_q.pop_front() : 32'hbad0);
        if (cfg_valid === 1'b1)
            check(32'({cfg_channel, cfg}),
                  cfg_q.size() ? cfg_q.pop_front() : 32'hbad1);
    end

    // watchdog
    initial
    begin
        #100000;
        failures++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        rd(SEL, 32'h0);
        rd(D1, 32'h0);
        $display("test reset done");
        // every crc code with delineation off and on
        for (int i = 0; i < 8; i++)
        begin
            c = 8'($random(seed));
            d = 16'($random(seed));
            d[14:12] = 3'(i);
            d[11] = 1'b0;
            wr(D1, {16'h0, d});
            wr(SEL, sel(1'b0, thpa_pkg::DIR_WRITE, c));
            repeat (3) @(negedge clk);
            req_valid = 1'b1;
            req_channel = c;
            cfg_q.push_back(32'({c, d[15], d[12], d[12],
                (d[12] && d[14:13] != 2'b11) ? d[14:13] : 2'b00, d[10:0]}));
            @(negedge clk);
            req_valid = 1'b0;
        end
        $display("test provision done");
        // host value holds until an indirect read replaces it
        wr(D1, 32'h0000_a5ff);
        rd(D1, 32'h0000_a000);
        wr(SEL, sel(1'b0, thpa_pkg::DIR_READ, c));
        rd(SEL, sel(1'b1, thpa_pkg::DIR_READ, c));
        rd(SEL, sel(1'b0, thpa_pkg::DIR_READ, c));
        rd(D1, {16'h0, d[15:12], 12'h0});
        $display("test readback done");
        // all lanes negated leaves both registers alone
        acc(1'b1, 1'b0, D1, 32'h0000_5000, 4'hf);
        acc(1'b1, 1'b0, SEL, sel(1'b0, 1'b0, ~c), 4'hf);
        acc(1'b0, 1'b1, D1, 32'h0, 4'hf);
        rd(D1, {16'h0, d[15:12], 12'h0});
        rd(SEL, sel(1'b0, thpa_pkg::DIR_READ, c));
        rd(12'h3f0, 32'h0);
        repeat (4) @(negedge clk);
        $display("test lanes done");
        finish_test();
    end
endmodule
